// File: pkg/watch_pkg.sv
// constants, field layouts and carriers of the watchpoint register bank
package watch_pkg;
	// ************************************
	// register indices, byte address = index * 4
	// ************************************
	localparam logic [7:0] IDX_DADDR2 = 8'h60;
	localparam logic [7:0] IDX_DCTRL = 8'h70;
	localparam logic [7:0] IDX_RMASK = 8'h80;
	localparam logic [7:0] IDX_RVALUE = 8'h90;
	localparam logic [7:0] IDX_RCTRL = 8'h9c;
	localparam logic [7:0] IDX_CAUSE = 8'ha0;
	localparam logic [7:0] IDX_CAPTURE = 8'ha1;
	localparam logic [7:0] IDX_INT_STATUS = 8'ha2;
	localparam logic [7:0] IDX_INT_MASK = 8'ha3;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;
	// ************************************
	// control word fields
	// ************************************
	localparam int THREAD_LSB = 16;
	localparam int THREAD_W = 8;
	localparam int LOAD_BIT = 2;
	localparam int COMB_BIT = 1;
	localparam int EN_BIT = 0;
	localparam logic [31:0] DCTRL_MASK = 32'h00ff_0007;
	localparam logic [31:0] RCTRL_MASK = 32'h00ff_0003;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// ************************************
	// cause register fields and codes
	// ************************************
	localparam int CAUSE_LSB = 0;
	localparam int CAUSE_W = 3;
	localparam int CTHREAD_LSB = 8;
	localparam int SRC_LSB = 16;
	localparam logic [2:0] CAUSE_DATA = 3'h4;
	localparam logic [2:0] CAUSE_RES = 3'h5;
	localparam int INT_DATA = 0;
	localparam int INT_RES = 1;
	localparam int INT_W = 2;
	// ************************************
	// carriers from the core pipeline
	// ************************************
	typedef struct packed {
		logic valid;
		logic load;
		logic store;
		logic [2:0] thread;
		logic [31:0] address;
	} mem_op_t;
	typedef struct packed {
		logic valid;
		logic [2:0] thread;
		logic [31:0] id;
	} res_op_t;
endpackage

// File: verification/core_ops_model.sv
// behavioural core pipeline issuing memory and resource operations
`timescale 1ns/100ps
module core_ops_model (
	input wire logic pclk,
	output watch_pkg::mem_op_t mem_op,
	output watch_pkg::res_op_t res_op
);
	// ************************************
	// one operation per call, after an optional stall
	// ************************************
	initial begin
		mem_op = '0;
		res_op = '0;
	end
	task automatic issue(input logic is_mem, input logic ld, input logic [2:0] thr,
		input logic [31:0] val, input int gap);
		repeat (gap) @(posedge pclk);
		@(posedge pclk);
		if (is_mem) begin
			mem_op <= '{valid: 1'b1, load: ld, store: !ld, thread: thr, address: val};
		end else begin
			res_op <= '{valid: 1'b1, thread: thr, id: val};
		end
		@(posedge pclk);
		// released fields carry inverted leftovers, never the last value
		mem_op <= '{valid: 1'b0, load: !ld, store: ld, thread: ~thr, address: ~val};
		res_op <= '{valid: 1'b0, thread: ~thr, id: ~val};
	endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the watchpoint register bank
`timescale 1ns/100ps
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, debug_mode;
	logic [31:0] paddr, pwdata, prdata, rdata;
	logic [127:0] first_addr;
	logic watch_hit, irq, err;
	watch_pkg::mem_op_t mem_op;
	watch_pkg::res_op_t res_op;
	int n_fail, n_checks;
	debug_watchpoint_registers u_debug_watchpoint_registers (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_mode(debug_mode),
		.data_watch_first_address(first_addr), .mem_op(mem_op), .res_op(res_op),
		.watch_hit(watch_hit), .irq(irq));
	core_ops_model u_core_ops_model (.pclk(pclk), .mem_op(mem_op), .res_op(res_op));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ************************************
	// shared tasks
	// ************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {22'h0, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			end_of_test();
		end else begin
			rdata = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rdata, exp);
	endtask
	task automatic op(input logic is_mem, input logic ld, input logic [2:0] thr,
		input logic [31:0] val, input logic hit);
		u_core_ops_model.issue(is_mem, ld, thr, val, int'(thr[0]));
		#1;
		chk({31'h0, watch_hit}, {31'h0, hit});
	endtask
	// ************************************
	// main sequence
	// ************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		debug_mode = 1'b0;
		first_addr = '0;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rchk(watch_pkg::IDX_DCTRL + 8'(i), 32'h0000_0000);
			rchk(watch_pkg::IDX_RCTRL + 8'(i), 32'h0000_0000);
		end
		apb(1'b1, watch_pkg::IDX_DADDR2, 32'hffff_ffff);
		chk({31'h0, err}, 32'h0000_0001);
		rchk(watch_pkg::IDX_DADDR2, 32'h0000_0000);
		apb(1'b0, 8'h64, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		chk(rdata, 32'h0000_0000);
		$display("test reset and refusal done");
		debug_mode <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, watch_pkg::IDX_DADDR2 + 8'(i), 32'ha5a5_0000 + 32'(i));
			apb(1'b1, watch_pkg::IDX_RMASK + 8'(i), 32'h5a5a_0000 + 32'(i));
			apb(1'b1, watch_pkg::IDX_RVALUE + 8'(i), 32'hc3c3_0000 + 32'(i));
			apb(1'b1, watch_pkg::IDX_DCTRL + 8'(i), 32'hff00_fff8 + 32'(i));
			apb(1'b1, watch_pkg::IDX_RCTRL + 8'(i), 32'hff5a_fffc);
		end
		for (int i = 0; i < 4; i++) begin
			rchk(watch_pkg::IDX_DADDR2 + 8'(i), 32'ha5a5_0000 + 32'(i));
			rchk(watch_pkg::IDX_RMASK + 8'(i), 32'h5a5a_0000 + 32'(i));
			rchk(watch_pkg::IDX_RVALUE + 8'(i), 32'hc3c3_0000 + 32'(i));
			rchk(watch_pkg::IDX_DCTRL + 8'(i), 32'(i));
			rchk(watch_pkg::IDX_RCTRL + 8'(i), 32'h005a_0000);
		end
		$display("test register words done");
		first_addr[63:32] <= 32'ha5a5_0001;
		apb(1'b1, watch_pkg::IDX_DCTRL + 8'h1, 32'h0008_0001);
		op(1'b1, 1'b0, 3'h3, 32'ha5a5_0001, 1'b1);
		rchk(watch_pkg::IDX_CAUSE, 32'h0001_0304);
		rchk(watch_pkg::IDX_CAPTURE, 32'ha5a5_0001);
		op(1'b1, 1'b1, 3'h3, 32'ha5a5_0001, 1'b0);
		op(1'b1, 1'b0, 3'h2, 32'ha5a5_0001, 1'b0);
		apb(1'b1, watch_pkg::IDX_DCTRL + 8'h1, 32'h0008_0005);
		op(1'b1, 1'b1, 3'h3, 32'ha5a5_0001, 1'b1);
		first_addr[63:32] <= 32'h0000_0000;
		op(1'b1, 1'b0, 3'h3, 32'ha5a5_0001, 1'b0);
		apb(1'b1, watch_pkg::IDX_DCTRL + 8'h1, 32'h0008_0003);
		op(1'b1, 1'b0, 3'h3, 32'ha5a5_0001, 1'b1);
		apb(1'b1, watch_pkg::IDX_DCTRL + 8'h3, 32'h0008_0003);
		op(1'b1, 1'b0, 3'h3, 32'ha5a5_0003, 1'b1);
		rchk(watch_pkg::IDX_CAUSE, 32'h0003_0304);
		apb(1'b1, watch_pkg::IDX_DADDR2 + 8'h3, 32'ha5a5_0001);
		op(1'b1, 1'b0, 3'h3, 32'ha5a5_0001, 1'b1);
		rchk(watch_pkg::IDX_CAUSE, 32'h0001_0304);
		apb(1'b1, watch_pkg::IDX_DCTRL + 8'h1, 32'h0008_0002);
		apb(1'b1, watch_pkg::IDX_DCTRL + 8'h3, 32'h0008_0002);
		op(1'b1, 1'b0, 3'h3, 32'ha5a5_0001, 1'b0);
		$display("test data watchpoints done");
		apb(1'b1, watch_pkg::IDX_RMASK + 8'h2, 32'h0000_ff00);
		apb(1'b1, watch_pkg::IDX_RVALUE + 8'h2, 32'h0000_1200);
		apb(1'b1, watch_pkg::IDX_RCTRL + 8'h2, 32'h0010_0001);
		op(1'b0, 1'b0, 3'h4, 32'habcd_12ef, 1'b1);
		rchk(watch_pkg::IDX_CAUSE, 32'h0002_0405);
		rchk(watch_pkg::IDX_CAPTURE, 32'habcd_12ef);
		op(1'b0, 1'b0, 3'h4, 32'habcd_13ef, 1'b0);
		op(1'b0, 1'b0, 3'h5, 32'habcd_12ef, 1'b0);
		apb(1'b1, watch_pkg::IDX_RCTRL + 8'h2, 32'h0010_0003);
		op(1'b0, 1'b0, 3'h4, 32'habcd_13ef, 1'b1);
		op(1'b0, 1'b0, 3'h4, 32'habcd_12ef, 1'b0);
		$display("test resource watchpoints done");
		rchk(watch_pkg::IDX_INT_STATUS, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0000_0000);
		debug_mode <= 1'b0;
		apb(1'b1, watch_pkg::IDX_INT_MASK, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, watch_pkg::IDX_INT_STATUS, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, irq}, 32'h0000_0000);
		rchk(watch_pkg::IDX_INT_STATUS, 32'h0000_0001);
		debug_mode <= 1'b1;
		apb(1'b1, watch_pkg::IDX_INT_STATUS, 32'h0000_0001);
		apb(1'b1, watch_pkg::IDX_INT_MASK, 32'h0000_0001);
		apb(1'b1, watch_pkg::IDX_DCTRL + 8'h1, 32'h0008_0003);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, irq}, 32'h0000_0000);
		op(1'b1, 1'b0, 3'h3, 32'ha5a5_0001, 1'b1);
		chk({31'h0, irq}, 32'h0000_0001);
		$display("test interrupt done");
		end_of_test();
	end
endmodule

// File: verilog/debug_watchpoint_registers.sv
// watchpoint register bank with apb slave, hit detection and interrupt
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module debug_watchpoint_registers #(
	parameter int N_WATCH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic debug_mode,
	input wire logic [N_WATCH*32-1:0] data_watch_first_address,
	input wire watch_pkg::mem_op_t mem_op,
	input wire watch_pkg::res_op_t res_op,
	output logic watch_hit,
	output logic irq
);
	logic [31:0] data_watch_second_address [N_WATCH];
	logic [31:0] data_watch_control [N_WATCH];
	logic [31:0] resource_watch_mask [N_WATCH];
	logic [31:0] resource_watch_value [N_WATCH];
	logic [31:0] resource_watch_control [N_WATCH];
	logic [31:0] next_daddr2 [N_WATCH];
	logic [31:0] next_dctrl [N_WATCH];
	logic [31:0] next_rmask [N_WATCH];
	logic [31:0] next_rvalue [N_WATCH];
	logic [31:0] next_rctrl [N_WATCH];
	logic [31:0] debug_cause_code, next_cause;
	logic [31:0] debug_capture_value, next_capture;
	logic [1:0] int_status, next_status;
	logic [1:0] int_mask, next_mask;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_watch_hit, next_irq;
	logic [N_WATCH-1:0] dhit, rhit, cond_a, cond_b, rmatch;
	logic [7:0] dthr [N_WATCH];
	logic [7:0] rthr [N_WATCH];
	logic [1:0] dsrc, rsrc;
	logic [7:0] idx;
	logic mapped, access, wr, debug_mode_read_write;

	// ************************************
	// hit detection
	// ************************************
	always_comb begin
		dsrc = 2'h0;
		rsrc = 2'h0;
		for (int i = N_WATCH - 1; i >= 0; i--) begin
			dthr[i] = data_watch_control[i][watch_pkg::THREAD_LSB +: watch_pkg::THREAD_W];
			rthr[i] = resource_watch_control[i][watch_pkg::THREAD_LSB +: watch_pkg::THREAD_W];
			cond_a[i] = mem_op.address == data_watch_first_address[i*32 +: 32];
			cond_b[i] = mem_op.address == data_watch_second_address[i];
			dhit[i] = mem_op.valid && data_watch_control[i][watch_pkg::EN_BIT]
				&& dthr[i][mem_op.thread]
				&& (mem_op.store || (mem_op.load
				&& data_watch_control[i][watch_pkg::LOAD_BIT]))
				&& (data_watch_control[i][watch_pkg::COMB_BIT] ? (cond_a[i] || cond_b[i])
				: (cond_a[i] && cond_b[i]));
			rmatch[i] = (res_op.id & resource_watch_mask[i])
				== resource_watch_value[i];
			rhit[i] = res_op.valid && resource_watch_control[i][watch_pkg::EN_BIT]
				&& rthr[i][res_op.thread]
				&& (resource_watch_control[i][watch_pkg::COMB_BIT]
				? !rmatch[i] : rmatch[i]);
			if (dhit[i]) begin
				dsrc = 2'(i);
			end
			if (rhit[i]) begin
				rsrc = 2'(i);
			end
		end
	end

	// ************************************
	// apb decode
	// ************************************
	always_comb begin
		idx = paddr[watch_pkg::IDX_LSB +: watch_pkg::IDX_W];
		access = psel && penable && pready;
		wr = access && pwrite && !pslverr;
		debug_mode_read_write = debug_mode;
		mapped = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0)
			&& ((idx[7:2] == watch_pkg::IDX_DADDR2[7:2])
			|| (idx[7:2] == watch_pkg::IDX_DCTRL[7:2])
			|| (idx[7:2] == watch_pkg::IDX_RMASK[7:2])
			|| (idx[7:2] == watch_pkg::IDX_RVALUE[7:2])
			|| (idx[7:2] == watch_pkg::IDX_RCTRL[7:2])
			|| (idx[7:2] == watch_pkg::IDX_CAUSE[7:2]));
		next_pready = psel && penable && !pready;
		next_pslverr = next_pready && (!mapped || (pwrite && !debug_mode_read_write
			&& idx != watch_pkg::IDX_INT_STATUS && idx != watch_pkg::IDX_INT_MASK));
		next_prdata = watch_pkg::WORD_RESET;
		if (next_pready && mapped && !pwrite) begin
			unique case (idx[7:2])
				watch_pkg::IDX_DADDR2[7:2]: next_prdata = data_watch_second_address[idx[1:0]];
				watch_pkg::IDX_DCTRL[7:2]: next_prdata = data_watch_control[idx[1:0]];
				watch_pkg::IDX_RMASK[7:2]: next_prdata = resource_watch_mask[idx[1:0]];
				watch_pkg::IDX_RVALUE[7:2]: next_prdata = resource_watch_value[idx[1:0]];
				watch_pkg::IDX_RCTRL[7:2]: next_prdata = resource_watch_control[idx[1:0]];
				default: begin
					unique case (idx[1:0])
						2'h0: next_prdata = debug_cause_code;
						2'h1: next_prdata = debug_capture_value;
						2'h2: next_prdata = {30'h0, int_status};
						default: next_prdata = {30'h0, int_mask};
					endcase
				end
			endcase
		end
	end

	// ************************************
	// register file next values
	// ************************************
	always_comb begin
		for (int i = 0; i < N_WATCH; i++) begin
			next_daddr2[i] = data_watch_second_address[i];
			next_dctrl[i] = data_watch_control[i];
			next_rmask[i] = resource_watch_mask[i];
			next_rvalue[i] = resource_watch_value[i];
			next_rctrl[i] = resource_watch_control[i];
			if (wr && idx[1:0] == 2'(i)) begin
				if (idx[7:2] == watch_pkg::IDX_DADDR2[7:2]) begin
					next_daddr2[i] = pwdata;
				end
				if (idx[7:2] == watch_pkg::IDX_DCTRL[7:2]) begin
					next_dctrl[i] = pwdata & watch_pkg::DCTRL_MASK;
				end
				if (idx[7:2] == watch_pkg::IDX_RMASK[7:2]) begin
					next_rmask[i] = pwdata;
				end
				if (idx[7:2] == watch_pkg::IDX_RVALUE[7:2]) begin
					next_rvalue[i] = pwdata;
				end
				if (idx[7:2] == watch_pkg::IDX_RCTRL[7:2]) begin
					next_rctrl[i] = pwdata & watch_pkg::RCTRL_MASK;
				end
			end
		end
	end

	// ************************************
	// cause, capture and interrupt next values
	// ************************************
	always_comb begin
		next_cause = debug_cause_code;
		next_capture = debug_capture_value;
		next_mask = int_mask;
		next_status = int_status;
		if (wr && idx == watch_pkg::IDX_CAUSE) begin
			next_cause = pwdata;
		end
		if (wr && idx == watch_pkg::IDX_CAPTURE) begin
			next_capture = pwdata;
		end
		if (wr && idx == watch_pkg::IDX_INT_MASK) begin
			next_mask = pwdata[watch_pkg::INT_W-1:0];
		end
		if (wr && idx == watch_pkg::IDX_INT_STATUS) begin
			next_status = int_status & ~pwdata[watch_pkg::INT_W-1:0];
		end
		// a hit in the clearing cycle wins over the clear
		if (|rhit) begin
			next_status[watch_pkg::INT_RES] = 1'b1;
		end
		if (|dhit) begin
			next_status[watch_pkg::INT_DATA] = 1'b1;
		end
		if (|dhit) begin
			next_cause = {14'h0, dsrc, 5'h0, mem_op.thread, 5'h0,
				watch_pkg::CAUSE_DATA};
			next_capture = mem_op.address;
		end else if (|rhit) begin
			next_cause = {14'h0, rsrc, 5'h0, res_op.thread, 5'h0,
				watch_pkg::CAUSE_RES};
			next_capture = res_op.id;
		end
		next_watch_hit = |dhit || |rhit;
		next_irq = |(next_status & next_mask);
	end

	// ************************************
	// registers
	// ************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_WATCH; i++) begin
				data_watch_second_address[i] <= watch_pkg::WORD_RESET;
				data_watch_control[i] <= watch_pkg::WORD_RESET;
				resource_watch_mask[i] <= watch_pkg::WORD_RESET;
				resource_watch_value[i] <= watch_pkg::WORD_RESET;
				resource_watch_control[i] <= watch_pkg::WORD_RESET;
			end
			debug_cause_code <= watch_pkg::WORD_RESET;
			debug_capture_value <= watch_pkg::WORD_RESET;
			int_status <= 2'h0;
			int_mask <= 2'h0;
			prdata <= watch_pkg::WORD_RESET;
			pready <= 1'b0;
			pslverr <= 1'b0;
			watch_hit <= 1'b0;
			irq <= 1'b0;
		end else begin
			data_watch_second_address <= next_daddr2;
			data_watch_control <= next_dctrl;
			resource_watch_mask <= next_rmask;
			resource_watch_value <= next_rvalue;
			resource_watch_control <= next_rctrl;
			debug_cause_code <= next_cause;
			debug_capture_value <= next_capture;
			int_status <= next_status;
			int_mask <= next_mask;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			watch_hit <= next_watch_hit;
			irq <= next_irq;
		end
	end

	// ************************************
	// assertions
	// ************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_data_hit;
		|dhit;
	endsequence
	sequence s_res_only;
		!(|dhit) && |rhit;
	endsequence
	sequence s_unmasked;
		|dhit && int_mask[watch_pkg::INT_DATA] && !(wr && idx == watch_pkg::IDX_INT_MASK);
	endsequence

	a_reserved_zero: assert property ((((data_watch_control[0] | data_watch_control[1]
		| data_watch_control[2] | data_watch_control[3]) & ~watch_pkg::DCTRL_MASK) == 0))
		else $error("reserved data control bits set");
	a_data_cause: assert property (s_data_hit |=> debug_cause_code[2:0] == 3'h4)
		else $error("data hit cause wrong");
	a_res_cause: assert property (s_res_only |=> debug_cause_code[2:0] == 3'h5)
		else $error("resource hit cause wrong");
	a_capture_address: assert property (s_data_hit |=> debug_capture_value
		== $past(mem_op.address)) else $error("address not captured");
	a_lowest_source: assert property (dhit[0] |=> debug_cause_code[17:16] == 2'h0)
		else $error("lowest watchpoint not reported");
	a_disabled_quiet: assert property (!data_watch_control[1][0] |-> !dhit[1])
		else $error("disabled watchpoint hit");
	a_thread_gate: assert property (dhit[2] |-> dthr[2][mem_op.thread])
		else $error("thread not enabled");
	a_load_gate: assert property (dhit[0] && !mem_op.store |-> data_watch_control[0][2])
		else $error("load hit without load trigger");
	a_and_combine: assert property (dhit[3] && !data_watch_control[3][1]
		|-> cond_a[3] && cond_b[3]) else $error("and combine broken");
	a_res_select: assert property (rhit[0] |-> (resource_watch_control[0][1]
		? !rmatch[0] : rmatch[0])) else $error("resource condition select broken");
	a_irq_raise: assert property (s_unmasked |=> irq && int_status[watch_pkg::INT_DATA])
		else $error("interrupt not raised");
	a_addr2_write: assert property (wr && idx == watch_pkg::IDX_DADDR2 |=>
		data_watch_second_address[0] == $past(pwdata)) else $error("second address lost");
	a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing");
	a_lowest_pair: assert property (dhit[1] && !dhit[0] |=> debug_cause_code[17:16] == 2'h1)
		else $error("lowest active watchpoint not reported");
	a_res_capture: assert property (s_res_only |=> debug_capture_value == $past(res_op.id))
		else $error("resource identifier not captured");
	a_res_thread: assert property (rhit[2] |-> rthr[2][res_op.thread])
		else $error("resource thread not enabled");
	a_store_only: assert property (dhit[1] && !data_watch_control[1][2] |-> mem_op.store)
		else $error("load hit with load trigger clear");
	a_res_reserved: assert property ((((resource_watch_control[0]
		| resource_watch_control[1] | resource_watch_control[2]
		| resource_watch_control[3]) & ~watch_pkg::RCTRL_MASK) == 0))
		else $error("reserved resource control bits set");
	// sticky status, hit pulse, interrupt level, idle read data and error answer
	a_status_set: assert property (s_data_hit |=> int_status[watch_pkg::INT_DATA])
		else $error("data status not set");
	a_hit_pulse: assert property ((|dhit || |rhit) |=> watch_hit)
		else $error("hit pulse missing");
	a_irq_level: assert property (irq == |(int_status & int_mask))
		else $error("interrupt level wrong");
	a_read_idle: assert property (!pready |-> prdata == watch_pkg::WORD_RESET)
		else $error("read data outside answer");
	a_error_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
endmodule
